// ### alu_pkg.sv
// Purpose: shared constants and types of the core arithmetic/logic unit
// Assumes: one 100 MHz clock, APB slave with 32-bit data, 8-bit paddr
// Notes: low I/O space of 32 byte registers is mirrored on the APB map
// What this block does
// - add two registers, with or without carry; update Z C N V H; one clock
// - subtract immediate from register into it; update Z C N V H; one clock
// - subtract registers, with or without carry; update Z C N V H; one clock
// - subtract immediate and carry from register; Z C N V H; one clock
// - add constant to 16-bit register pair; update Z C N V S; two clocks
// - subtract constant from 16-bit register pair; Z C N V S; two clocks
// - and with register or constant; update only Z N V; one clock
// - or with register or constant; update Z N V; one clock
// - exclusive or of two registers; update Z N V; one clock
// - invert register as 0xff minus value; update Z C N V; one clock
// - set bits: or register with immediate mask; Z N V; one clock
// - clear bits: and with 0xff minus mask; Z N V; one clock
// - I/O addresses 0x00 to 0x1f allow single-bit set and clear, except reserved 0x02, 0x09, 0x0a and 0x11
// - any bit in that range testable by skip-if-set and skip-if-clear
// - some I/O status flags clear when software writes one to them
// - bit set/clear writes only the addressed bit, safe on such flags
package alu_pkg;

  // apb byte addresses
  localparam logic [7:0] ADDR_OPA = 8'h00;
  localparam logic [7:0] ADDR_OPB = 8'h04;
  localparam logic [7:0] ADDR_OPH = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_SREG = 8'h10;
  localparam logic [7:0] ADDR_RES = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_IO_BASE = 8'h80;

  // field layout
  localparam int CMD_OP_W = 5;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;
  localparam int IO_COUNT = 32;
  localparam int IMM_WORD_W = 6;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_ADD_CARRY = 5'h01, OP_ADD_IMM_WORD = 5'h02,
    OP_SUB = 5'h03, OP_SUB_IMM = 5'h04, OP_SUB_CARRY = 5'h05,
    OP_SUB_CARRY_IMM = 5'h06, OP_SUB_IMM_WORD = 5'h07,
    OP_AND = 5'h08, OP_AND_IMM = 5'h09, OP_OR = 5'h0a, OP_OR_IMM = 5'h0b,
    OP_XOR = 5'h0c, OP_INVERT = 5'h0d, OP_NEGATE = 5'h0e,
    OP_SET_BITS = 5'h0f, OP_CLEAR_BITS = 5'h10, OP_INC = 5'h11,
    OP_DEC = 5'h12, OP_SET_IO_BIT = 5'h13, OP_CLEAR_IO_BIT = 5'h14,
    OP_SKIP_IO_SET = 5'h15, OP_SKIP_IO_CLEAR = 5'h16
  } alu_op_t;

  // gray codes: idle -> word high -> idle, idle -> bit write -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WORD_HI = 2'b01, ST_BIT_WR = 2'b10
  } alu_state_t;

  typedef struct packed {
    logic i, t, h, s, v, n, z, c;
  } alu_flags_t;

  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    logic [7:0] mask;
  } alu_io_evt_t;

  // flags that clear when written with one, per I/O address
  function automatic logic [7:0] w1c_mask(input logic [4:0] a);
    case (a)
      5'h06: w1c_mask = 8'h10;
      5'h08: w1c_mask = 8'h10;
      5'h0b: w1c_mask = 8'h27;
      5'h0e: w1c_mask = 8'he0;
      default: w1c_mask = 8'h00;
    endcase
  endfunction

  function automatic logic io_reserved(input logic [4:0] a);
    io_reserved = (a == 5'h02) || (a == 5'h09) || (a == 5'h0a) ||
      (a == 5'h11);
  endfunction

  function automatic logic [7:0] bit_sel(input logic [2:0] idx);
    bit_sel = 8'h01 << idx;
  endfunction

  function automatic logic is_zero(input logic [7:0] r);
    is_zero = (r == 8'h00);
  endfunction

endpackage

// ### alu_addsub.sv
// Purpose: 8-bit adder/subtractor with carry and arithmetic flags
// Assumes: purely combinational, borrow reported on c when subtracting
// Notes: r = a + b + cin, or r = a - b - cin when sub is high
module alu_addsub (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic sub,
  output logic [7:0] r,
  output logic c,
  output logic h,
  output logic v
);
  import alu_pkg::*;

  logic [8:0] sum;

  // nine bits so the top bit is carry out or borrow
  always_comb begin
    if (sub) begin
      sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    end else begin
      sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    end
  end

  assign r = sum[7:0];
  assign c = sum[8];

  // half carry out of bit 3, and signed overflow
  always_comb begin
    if (sub) begin
      h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    end else begin
      h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
    end
  end

endmodule

// ### alu_iobank.sv
// Purpose: low I/O space, 32 byte registers with masked writes
// Assumes: hardware events and writes arrive on the same clock
// Notes: reserved addresses hold no storage and read as zero
module alu_iobank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_mask,
  input wire logic [7:0] wr_data,
  input wire alu_pkg::alu_io_evt_t evt,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data
);
  import alu_pkg::*;

  logic [7:0] mem [0:IO_COUNT-1];
  logic [7:0] next_mem [0:IO_COUNT-1];

  // only bits in wr_mask are touched; a flag bit clears on one
  always_comb begin
    for (int i = 0; i < IO_COUNT; i++) begin
      next_mem[i] = mem[i];
      if (wr_en && (wr_addr == 5'(i))) begin
        next_mem[i] = (mem[i] & ~wr_mask) |
          (wr_data & wr_mask & ~w1c_mask(5'(i))) |
          (mem[i] & wr_mask & w1c_mask(5'(i)) & ~wr_data);
      end
      // set wins over a clear in the same cycle
      if (evt.valid && (evt.addr == 5'(i))) begin
        next_mem[i] = next_mem[i] | evt.mask;
      end
      if (io_reserved(5'(i))) begin
        next_mem[i] = RST_BYTE;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < IO_COUNT; i++) begin
        mem[i] <= RST_BYTE;
      end
    end else begin
      for (int i = 0; i < IO_COUNT; i++) begin
        mem[i] <= next_mem[i];
      end
    end
  end

  assign rd_data = mem[rd_addr];

endmodule

// ### alu_core.sv
// Purpose: arithmetic/logic execution unit with APB register access
// Assumes: one clock mclk at 100 MHz, asynchronous active-high rst
// Notes: a write to the command register launches one operation;
//   operands come from the opa, opb and oph registers
//
// Register access over APB and the address map were decided locally.
module alu_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire alu_pkg::alu_io_evt_t io_evt,
  output logic io_skip,
  output logic busy
);
  import alu_pkg::*;

  // operand and result state
  logic [7:0] opa;
  logic [7:0] opb;
  logic [7:0] oph;
  logic [15:0] result;
  alu_flags_t sreg;
  alu_state_t state;
  alu_op_t word_op;
  logic word_cy;
  logic [4:0] bit_addr;
  logic [7:0] bit_mask;
  logic bit_set;

  // bus decode
  logic acc;
  logic wr_fire;
  logic io_hit;
  logic mapped;
  logic cmd_fire;
  alu_op_t cmd_op;

  // datapath wires
  logic [7:0] as_a;
  logic [7:0] as_b;
  logic as_cin;
  logic as_sub;
  logic [7:0] as_r;
  logic as_c;
  logic as_h;
  logic as_v;
  logic [7:0] next_res;
  alu_flags_t next_flags;
  logic next_skip;
  logic [15:0] word_r;

  // I/O bank wires
  logic io_wr_en;
  logic [4:0] io_wr_addr;
  logic [7:0] io_wr_mask;
  logic [7:0] io_wr_data;
  logic [4:0] io_rd_addr;
  logic [7:0] io_rd_data;

  // access phase waits one cycle so prdata can come from a flop
  assign acc = psel & penable;
  assign wr_fire = acc & pready & pwrite;
  assign io_hit = paddr[7] & (paddr[1:0] == 2'b00) &
    ~io_reserved(paddr[6:2]);
  assign mapped = io_hit || (paddr == ADDR_OPA) || (paddr == ADDR_OPB) ||
    (paddr == ADDR_OPH) || (paddr == ADDR_CMD) || (paddr == ADDR_SREG) ||
    (paddr == ADDR_RES) || (paddr == ADDR_STAT);
  assign cmd_fire = wr_fire && (paddr == ADDR_CMD) &&
    (state == ST_IDLE);
  assign cmd_op = alu_op_t'(pwdata[CMD_OP_W-1:0]);

  // adder operand selection; the word high byte reuses the same adder
  always_comb begin
    as_a = opa;
    as_b = opb;
    as_cin = 1'b0;
    as_sub = 1'b0;
    if (state == ST_WORD_HI) begin
      as_a = oph;
      as_b = RST_BYTE;
      as_cin = word_cy;
      as_sub = (word_op == OP_SUB_IMM_WORD);
    end else begin
      unique case (cmd_op)
        OP_ADD_CARRY: as_cin = sreg.c;
        OP_SUB, OP_SUB_IMM: as_sub = 1'b1;
        OP_SUB_CARRY, OP_SUB_CARRY_IMM: begin
          as_sub = 1'b1;
          as_cin = sreg.c;
        end
        OP_ADD_IMM_WORD: as_b = {2'b00, opb[IMM_WORD_W-1:0]};
        OP_SUB_IMM_WORD: begin
          as_b = {2'b00, opb[IMM_WORD_W-1:0]};
          as_sub = 1'b1;
        end
        OP_NEGATE: begin
          as_a = RST_BYTE;
          as_b = opa;
          as_sub = 1'b1;
        end
        OP_INC: as_b = 8'h01;
        OP_DEC: begin
          as_b = 8'h01;
          as_sub = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  alu_addsub u_addsub (
    .a(as_a),
    .b(as_b),
    .cin(as_cin),
    .sub(as_sub),
    .r(as_r),
    .c(as_c),
    .h(as_h),
    .v(as_v)
  );

  // sixteen-bit result as it stands in the second word cycle
  assign word_r = {as_r, result[7:0]};

  // one-clock result and flag update for each command; word ops give only their low byte here
  always_comb begin
    next_res = opa;
    next_flags = sreg;
    next_skip = 1'b0;
    unique case (cmd_op)
      OP_ADD, OP_ADD_CARRY: begin
        next_res = as_r;
        next_flags.z = is_zero(as_r);
        next_flags.c = as_c;
        next_flags.n = as_r[7];
        next_flags.v = as_v;
        next_flags.h = as_h;
      end
      OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_CARRY_IMM: begin
        next_res = as_r;
        next_flags.z = is_zero(as_r);
        next_flags.c = as_c;
        next_flags.n = as_r[7];
        next_flags.v = as_v;
        next_flags.h = as_h;
      end
      OP_NEGATE: begin
        next_res = as_r;
        next_flags.z = is_zero(as_r);
        next_flags.c = as_c;
        next_flags.n = as_r[7];
        next_flags.v = as_v;
        next_flags.h = as_h;
      end
      OP_INC, OP_DEC: begin
        next_res = as_r;
        next_flags.z = is_zero(as_r);
        next_flags.n = as_r[7];
        next_flags.v = as_v;
      end
      OP_AND, OP_AND_IMM: begin
        next_res = opa & opb;
        next_flags.z = is_zero(opa & opb);
        next_flags.n = next_res[7];
        next_flags.v = 1'b0;
      end
      OP_OR, OP_OR_IMM, OP_SET_BITS: begin
        next_res = opa | opb;
        next_flags.z = is_zero(opa | opb);
        next_flags.n = next_res[7];
        next_flags.v = 1'b0;
      end
      OP_XOR: begin
        next_res = opa ^ opb;
        next_flags.z = is_zero(opa ^ opb);
        next_flags.n = next_res[7];
        next_flags.v = 1'b0;
      end
      OP_INVERT: begin
        next_res = 8'hff - opa;
        next_flags.z = is_zero(8'hff - opa);
        next_flags.c = 1'b1;
        next_flags.n = next_res[7];
        next_flags.v = 1'b0;
      end
      OP_CLEAR_BITS: begin
        next_res = opa & (8'hff - opb);
        next_flags.z = is_zero(opa & (8'hff - opb));
        next_flags.n = next_res[7];
        next_flags.v = 1'b0;
      end
      OP_ADD_IMM_WORD, OP_SUB_IMM_WORD: begin
        next_res = as_r; // low byte now, flags in the second clock
      end
      OP_SKIP_IO_SET: begin
        next_skip = |(io_rd_data & bit_sel(opb[2:0]));
      end
      OP_SKIP_IO_CLEAR: begin
        next_skip = ~|(io_rd_data & bit_sel(opb[2:0]));
      end
      default: begin
        next_res = opa;
      end
    endcase
  end

  // sequencer: word ops and I/O bit writes take a second clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_fire && ((cmd_op == OP_ADD_IMM_WORD) ||
              (cmd_op == OP_SUB_IMM_WORD))) begin
            state <= ST_WORD_HI;
          end else if (cmd_fire && ((cmd_op == OP_SET_IO_BIT) ||
              (cmd_op == OP_CLEAR_IO_BIT))) begin
            state <= ST_BIT_WR;
          end
        end
        ST_WORD_HI: state <= ST_IDLE;
        ST_BIT_WR: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // context carried into the second clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      word_op <= OP_ADD;
      word_cy <= 1'b0;
      bit_addr <= 5'h00;
      bit_mask <= RST_BYTE;
      bit_set <= 1'b0;
    end else if (cmd_fire) begin
      word_op <= cmd_op;
      word_cy <= as_c;
      bit_addr <= opa[4:0];
      bit_mask <= bit_sel(opb[2:0]);
      bit_set <= (cmd_op == OP_SET_IO_BIT);
    end
  end

  // result register; the word result holds both bytes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result <= RST_WORD;
    end else if (state == ST_WORD_HI) begin
      result[15:8] <= as_r;
    end else if (cmd_fire) begin
      result <= {8'h00, next_res};
    end
  end

  // status flags; software may preload carry or any flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sreg <= '0;
    end else if (state == ST_WORD_HI) begin
      sreg.z <= (word_r == RST_WORD);
      sreg.n <= word_r[15];
      if (word_op == OP_SUB_IMM_WORD) begin
        sreg.v <= oph[7] & ~word_r[15];
        sreg.c <= word_r[15] & ~oph[7];
        sreg.s <= word_r[15] ^ (oph[7] & ~word_r[15]);
      end else begin
        sreg.v <= ~oph[7] & word_r[15];
        sreg.c <= ~word_r[15] & oph[7];
        sreg.s <= word_r[15] ^ (~oph[7] & word_r[15]);
      end
    end else if (cmd_fire) begin
      sreg <= next_flags;
    end else if (wr_fire && (paddr == ADDR_SREG)) begin
      sreg <= alu_flags_t'(pwdata[7:0]);
    end
  end

  // skip answer of the last command; any command but a bit test clears it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      io_skip <= 1'b0;
    end else if (cmd_fire) begin
      io_skip <= next_skip;
    end
  end

  // operand registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      opa <= RST_BYTE;
      opb <= RST_BYTE;
      oph <= RST_BYTE;
    end else if (wr_fire) begin
      if (paddr == ADDR_OPA) begin
        opa <= pwdata[7:0];
      end
      if (paddr == ADDR_OPB) begin
        opb <= pwdata[7:0];
      end
      if (paddr == ADDR_OPH) begin
        oph <= pwdata[7:0];
      end
    end
  end

  // busy flag mirrors the second clock of two-clock operations
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= cmd_fire && ((cmd_op == OP_ADD_IMM_WORD) ||
        (cmd_op == OP_SUB_IMM_WORD) || (cmd_op == OP_SET_IO_BIT) ||
        (cmd_op == OP_CLEAR_IO_BIT));
    end
  end

  // I/O bank port: bit op writes one bit only, bus writes the byte
  always_comb begin
    io_wr_en = 1'b0;
    io_wr_addr = paddr[6:2];
    io_wr_mask = 8'hff;
    io_wr_data = pwdata[7:0];
    if (state == ST_BIT_WR) begin
      io_wr_en = 1'b1;
      io_wr_addr = bit_addr;
      io_wr_mask = bit_mask;
      io_wr_data = bit_set ? 8'hff : 8'h00;
    end else if (wr_fire && io_hit) begin
      io_wr_en = 1'b1;
    end
  end

  // reads from the bus win the read port; tests use the opa address
  assign io_rd_addr = (acc && !pwrite) ? paddr[6:2] : opa[4:0];

  alu_iobank u_iobank (
    .mclk(mclk),
    .rst(rst),
    .wr_en(io_wr_en),
    .wr_addr(io_wr_addr),
    .wr_mask(io_wr_mask),
    .wr_data(io_wr_data),
    .evt(io_evt),
    .rd_addr(io_rd_addr),
    .rd_data(io_rd_data)
  );

  // apb ready: one wait state in every access phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= acc & ~pready;
    end
  end

  // error on unmapped address or a command while busy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else if (acc && !pready) begin
      pslverr <= !mapped || (pwrite && (paddr == ADDR_CMD) &&
        (state != ST_IDLE));
    end else begin
      pslverr <= 1'b0;
    end
  end

  // read data, captured in the wait state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (acc && !pready && !pwrite) begin
      if (io_hit) begin
        prdata <= {24'h000000, io_rd_data};
      end else begin
        unique case (paddr)
          ADDR_OPA: prdata <= {24'h000000, opa};
          ADDR_OPB: prdata <= {24'h000000, opb};
          ADDR_OPH: prdata <= {24'h000000, oph};
          ADDR_SREG: prdata <= {24'h000000, sreg};
          ADDR_RES: prdata <= {16'h0000, result};
          ADDR_STAT: prdata <= {30'h00000000, io_skip, state != ST_IDLE};
          default: prdata <= 32'h00000000;
        endcase
      end
    end else begin
      prdata <= 32'h00000000;
    end
  end

endmodule

// ### cal_asserts.sv
// Purpose: concurrent checks on the arithmetic unit's bus and status pins
// Assumes: single clock domain, reset active high
// Notes: command accepts are rebuilt from the bus pins, not taken from inside
module cal_asserts import alu_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic io_skip,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic acc;
  logic rd_acc;
  logic cmd_acc;
  logic word_op;
  logic bit_op;
  // accepted transfers, decoded once for every property
  assign acc = psel && penable && pready;
  assign rd_acc = acc && !pwrite;
  assign cmd_acc = acc && pwrite && paddr == ADDR_CMD && !pslverr;
  assign word_op = pwdata[4:0] == OP_ADD_IMM_WORD ||
    pwdata[4:0] == OP_SUB_IMM_WORD;
  assign bit_op = pwdata[4:0] == OP_SET_IO_BIT ||
    pwdata[4:0] == OP_CLEAR_IO_BIT;
  ready_one_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_wait_a: assert property (psel && !penable |-> ##2 pready)
    else $error("answer not at second access cycle");
  idle_quiet_a: assert property (!psel |-> !pready && prdata == 32'h0)
    else $error("answer outside a transfer");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // i/o bit writes take a second clock just like word ops
  word_busy_a: assert property (cmd_acc && (word_op || bit_op)
    |=> busy ##1 !busy)
    else $error("two-clock op not two clocks");
  one_clock_a: assert property (cmd_acc && !(word_op || bit_op)
    |=> !busy)
    else $error("byte op took a second clock");
  resv_refuse_a: assert property (acc && (paddr == 8'h88 ||
    paddr == 8'ha4 || paddr == 8'ha8 || paddr == 8'hc4) |-> pslverr)
    else $error("reserved address accepted");
  skip_cause_a: assert property (!$stable(io_skip) |-> $past(cmd_acc))
    else $error("skip changed without a command");
  res_upper_a: assert property (rd_acc && paddr == ADDR_RES |->
    prdata[31:16] == 16'h0)
    else $error("result upper bits set");
  cmd_zero_a: assert property (rd_acc && paddr == ADDR_CMD |-> prdata == 32'h0)
    else $error("command register readable");
  word_c: cover property (cmd_acc && word_op);
  refuse_c: cover property (acc && pslverr);
  skip_c: cover property (io_skip);
endmodule
bind alu_core cal_asserts u_chk (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_skip(io_skip),
  .busy(busy));

// ### cal_evt_model.sv
// Purpose: hardware side that raises status flags in the low I/O space
// Assumes: events are one-cycle pulses on the core clock
// Notes: idle fields churn, so a bank that ignores valid gets caught
module cal_evt_model import alu_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [4:0] addr,
  input wire logic [7:0] mask,
  output alu_pkg::alu_io_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] junk;
  // pulse one event per request, junk on the fields otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      junk <= 13'h1a5b;
      evt <= '0;
    end else begin
      junk <= junk + 13'h0b3d;
      evt.valid <= fire;
      evt.addr <= fire ? addr : junk[4:0];
      evt.mask <= fire ? mask : junk[12:5];
    end
  end
endmodule

// ### tb_core_arith_logic_unit.sv
// Purpose: self-checking bench for the arithmetic unit over APB
// Assumes: one idle cycle between transfers, answers taken at ready edge
// Notes: expected values come from a reference model in this bench
module tb_core_arith_logic_unit import alu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, io_skip, busy;
  logic [7:0] paddr, fmask, a, b, h, sr;
  logic [31:0] pwdata, prdata;
  logic [4:0] faddr;
  logic fire;
  logic [15:0] lf;
  logic [23:0] x;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  alu_io_evt_t io_evt;
  int n_errors, cmp_count;
  alu_core u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_evt(io_evt),
    .io_skip(io_skip), .busy(busy));
  cal_evt_model u_evt (.mclk(mclk), .rst(rst), .fire(fire), .addr(faddr),
    .mask(fmask), .evt(io_evt));
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // reference result {res, sreg}; flags not named by an op stay as given
  function automatic logic [23:0] ref_op(input logic [4:0] op,
      input logic [7:0] a, b, hb, sr);
    logic [8:0] t;
    logic [4:0] q;
    logic [16:0] w;
    logic [7:0] r;
    logic sub, ci;
    ci = (op == OP_ADD_CARRY || op == OP_SUB_CARRY ||
      op == OP_SUB_CARRY_IMM) && sr[0];
    sub = op inside {OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_CARRY_IMM,
      OP_NEGATE};
    if (op == OP_NEGATE) begin
      b = a;
      a = 8'h00;
    end
    t = sub ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
    q = sub ? {1'b0, a[3:0]} - b[3:0] - ci : {1'b0, a[3:0]} + b[3:0] + ci;
    r = t[7:0];
    sr[3] = 1'b0;
    case (op)
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_IMM, OP_SUB_CARRY,
      OP_SUB_CARRY_IMM, OP_NEGATE: begin
        sr[5] = q[4];
        sr[0] = t[8];
        sr[3] = (sub ? a[7] != b[7] : a[7] == b[7]) && r[7] != a[7];
      end
      OP_AND, OP_AND_IMM: r = a & b;
      OP_OR, OP_OR_IMM, OP_SET_BITS: r = a | b;
      OP_XOR: r = a ^ b;
      OP_CLEAR_BITS: r = a & ~b;
      OP_INVERT: begin
        r = ~a;
        sr[0] = 1'b1;
      end
      OP_INC: begin
        r = a + 8'h01;
        sr[3] = r == 8'h80;
      end
      OP_DEC: begin
        r = a - 8'h01;
        sr[3] = r == 8'h7f;
      end
      default: begin
        w = (op == OP_ADD_IMM_WORD) ? {1'b0, hb, a} + b[5:0] :
          {1'b0, hb, a} - b[5:0];
        sr[0] = w[16];
        sr[3] = (op == OP_ADD_IMM_WORD) ? !hb[7] && w[15] : hb[7] && !w[15];
        sr[2] = w[15];
        sr[1] = w[15:0] == 16'h0000;
        sr[4] = sr[2] ^ sr[3];
        return {w[15:0], sr};
      end
    endcase
    sr[2] = r[7];
    sr[1] = r == 8'h00;
    return {8'h00, r, sr};
  endfunction
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one APB transfer; the answer expected is queued for the monitor
  task automatic apb(input logic [7:0] ad, input logic w,
      input logic [31:0] d, input logic [32:0] ex);
    int k;
    exp_q.push_back(ex);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    // ready is sampled at the rising edge that takes the transfer
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t: no ready", $time);
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(ad, 1'b1, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] v);
    apb(ad, 1'b0, 32'h0, {1'b0, v});
  endtask
  task automatic io_cmd(input logic [4:0] ad, input logic [2:0] bi,
      input logic [4:0] op);
    wr(ADDR_OPA, {27'h0, ad});
    wr(ADDR_OPB, {29'h0, bi});
    wr(ADDR_CMD, {27'h0, op});
  endtask
  // monitor: every answer is matched with the oldest queued note
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("ERROR %0t: answer without request", $time);
      end else begin
        e = exp_q.pop_front();
        `CHK({pslverr, prdata}, e)
      end
    end
  end
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; fire = 1'b0; faddr = 5'h00;
    fmask = 8'h00; lf = 16'h0063; n_errors = 0; cmp_count = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
    rd(8'hcc, 32'h0);
    apb(8'h1c, 1'b0, 32'h0, {1'b1, 32'h0});
    // reserved i/o is only probed by a read; software never writes there
    apb(8'h88, 1'b0, 32'h0, {1'b1, 32'h0});
    apb(8'h83, 1'b1, 32'hff, {1'b1, 32'h0});
    $display("test reset and refusal done");
    for (int o = 0; o <= 18; o++) begin
      for (int k = 0; k < 3; k++) begin
        lf = lfsr(lf); a = lf[7:0]; b = lf[15:8];
        lf = lfsr(lf); h = lf[7:0]; sr = lf[15:8];
        if (k == 0) begin
          a = 8'hff; b = 8'h01; h = 8'hff;
        end
        wr(ADDR_OPA, {24'h0, a}); wr(ADDR_OPB, {24'h0, b});
        wr(ADDR_OPH, {24'h0, h}); wr(ADDR_SREG, {24'h0, sr});
        wr(ADDR_CMD, {27'h0, 5'(o)});
        x = ref_op(5'(o), a, b, h, sr);
        rd(ADDR_RES, {16'h0, x[23:8]});
        rd(ADDR_SREG, {24'h0, x[7:0]});
        rd(ADDR_STAT, 32'h0);
      end
    end
    $display("test operations done");
    wr(8'hcc, 32'h5a);
    io_cmd(5'h13, 3'd0, OP_SET_IO_BIT);
    rd(8'hcc, 32'h5b);
    io_cmd(5'h13, 3'd6, OP_CLEAR_IO_BIT);
    rd(8'hcc, 32'h1b);
    io_cmd(5'h13, 3'd4, OP_SKIP_IO_SET);
    rd(ADDR_STAT, 32'h2);
    io_cmd(5'h13, 3'd4, OP_SKIP_IO_CLEAR);
    rd(ADDR_STAT, 32'h0);
    io_cmd(5'h13, 3'd2, OP_SKIP_IO_CLEAR);
    rd(ADDR_STAT, 32'h2);
    fire <= 1'b1; faddr <= 5'h0b; fmask <= 8'h27;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(8'hac, 32'h27);
    io_cmd(5'h0b, 3'd0, OP_SET_IO_BIT);
    rd(8'hac, 32'h26);
    io_cmd(5'h0b, 3'd1, OP_CLEAR_IO_BIT);
    wr(8'hac, 32'h04);
    rd(8'hac, 32'h22);
    $display("test io bits done");
    if (exp_q.size() != 0) n_errors++;
    wrap_up();
  end
endmodule
